//--- rtl/dmt_pkg.sv
package dmt_pkg;

  // core clock and programmable tap periods
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_10K7_NS     = 93500;
  localparam int T_1K_NS       = 1000000;
  localparam int T_100_NS      = 10000000;
  localparam int T_10_NS       = 100000000;
  localparam int T_1_NS        = 1000000000;
  localparam int DIV_10K7_CYC  = T_10K7_NS / CLK_PERIOD_NS;
  localparam int DIV_1K_CYC    = T_1K_NS / CLK_PERIOD_NS;
  localparam int DIV_100_CYC   = T_100_NS / CLK_PERIOD_NS;
  localparam int DIV_10_CYC    = T_10_NS / CLK_PERIOD_NS;
  localparam int DIV_1_CYC     = T_1_NS / CLK_PERIOD_NS;
  localparam int PRESC_W       = 27;

  // register port addresses (page 0)
  localparam logic [4:0] ADDR_STATUS   = 5'h00;
  localparam logic [4:0] ADDR_T0_CTRL  = 5'h01;
  localparam logic [4:0] ADDR_T1_CTRL  = 5'h02;
  localparam logic [4:0] ADDR_OUT_MODE = 5'h02;
  localparam logic [4:0] ADDR_T0_LOW   = 5'h0F;
  localparam logic [4:0] ADDR_T0_HIGH  = 5'h10;
  localparam logic [4:0] ADDR_T1_LOW   = 5'h11;
  localparam logic [4:0] ADDR_T1_HIGH  = 5'h12;

  // field positions and reset values
  localparam int         ST_RS_BIT    = 6;
  localparam int         ST_PS_BIT    = 7;
  localparam int         OM_INV_BIT   = 0;
  localparam int         OM_OD_BIT    = 1;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [1:0] OM_RST       = 2'h0;
  localparam logic [7:0] PRESET_RST   = 8'h00;

  // clock select codes
  localparam logic [2:0] CS_CASCADE   = 3'h0;
  localparam logic [2:0] CS_XTAL      = 3'h1;
  localparam logic [2:0] CS_XTAL_DIV4 = 3'h2;
  localparam logic [2:0] CS_10K7      = 3'h3;
  localparam logic [2:0] CS_1K        = 3'h4;
  localparam logic [2:0] CS_100       = 3'h5;
  localparam logic [2:0] CS_10        = 3'h6;
  localparam logic [2:0] CS_1         = 3'h7;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_RATE,
    MODE_SQUARE,
    MODE_ONESHOT
  } dmt_mode_t;

  typedef struct packed {
    logic       count_hold_gate_bit;
    logic       read_latch;
    logic [2:0] clk_sel;
    dmt_mode_t  mode;
    logic       timer_run_bit;
  } dmt_ctrl_t;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } dmt_bus_req_t;

endpackage

//--- rtl/dmt_timer.sv
// Contract
// - clock select picks each timer's count clock
// - timer zero cascades from timer one output
// - per-timer prescaler bounds start uncertainty
// - hold bit pauses, or triggers one-shot
// - mode field selects four count modes
// - single pulse: start loads, output high
// - single pulse: high until zero, N periods
// - single pulse: zero interrupts, clears run
// - single pulse: hold bit or gate pauses
// - output invertible, push-pull or open-drain
// - rate: start loads preset, output high
// - rate: low one clock, reload, N+1
// - rate: interrupt at every zero
// - square: start loads preset, output high
// - square: toggle and reload every N+1
// - square: interrupt on output falling edge
// - one-shot: trigger sets output, then loads
// - one-shot: retrigger reloads, output unchanged
// - one-shot: N periods, interrupt at zero
// - data reads return preset normally
// - latch bit snapshots count; low read clears
// - latch write synchronised to decrement clock; code snapshots the count at the write's core clock edge
// - five address bits, page/block select
// - sixteen-bit down counter on clock edge
// - stopping resets prescaler and counter
// - writing latch zero abandons latched read
// - only timer zero reaches output pin
`timescale 1ns/1ps
module dmt_timer
  import dmt_pkg::*;
#(
  parameter int P_DIV_10K7 = DIV_10K7_CYC,
  parameter int P_DIV_1K   = DIV_1K_CYC,
  parameter int P_DIV_100  = DIV_100_CYC,
  parameter int P_DIV_10   = DIV_10_CYC,
  parameter int P_DIV_1    = DIV_1_CYC
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_ce,
  input  wire dmt_bus_req_t i_bus_req,
  output logic [7:0]        o_rdata,
  input  wire logic         i_xtal_tick,
  input  wire logic         i_gate_input_timer_zero,
  input  wire logic         i_gate_input_timer_one,
  output logic              o_multi_function_output_o,
  output logic              o_multi_function_output_oe,
  output logic [1:0]        o_timer_irq
);

  logic [1:0]         rst_sync_q;
  logic               rst_n;
  dmt_ctrl_t          ctrl_q     [2];
  logic [7:0]         pre_lo_q   [2];
  logic [7:0]         pre_hi_q   [2];
  logic [15:0]        cnt_q      [2];
  logic [15:0]        snap_q     [2];
  logic [15:0]        preset     [2];
  logic [PRESC_W-1:0] presc_q    [2];
  logic [1:0]         out_q;
  logic [1:0]         loaded_q;
  logic [1:0]         pend_q;
  logic [1:0]         gate_prev_q;
  logic [1:0]         irq_q;
  logic               t1_prev_q;
  logic               page_q;
  logic               blk_q;
  logic [1:0]         om_q;
  logic [7:0]         rdata_q;
  logic [7:0]         rdata_d;
  logic               mfo_o_q;
  logic               mfo_oe_q;
  logic [1:0]         gate;
  logic [1:0]         tick;
  logic [1:0]         held;
  logic [1:0]         tick_en;
  logic [1:0]         trig;
  logic [1:0]         done;
  logic [1:0]         ctrl_wr;
  logic [1:0]         lo_rd;
  logic [1:0]         lo_wr;
  logic [1:0]         hi_wr;
  logic               wr_en;
  logic               rd_en;
  logic               t1_fall;
  logic               mfo_val;

  function automatic logic [4:0] data_addr(input int t, input logic hi);
    data_addr = ADDR_T0_LOW + 5'(2 * t) + {4'h0, hi};
  endfunction

  function automatic logic [PRESC_W-1:0] presc_top(input logic [2:0] sel);
    unique case (sel)
      CS_10K7: presc_top = PRESC_W'(P_DIV_10K7 - 1);
      CS_1K:   presc_top = PRESC_W'(P_DIV_1K - 1);
      CS_100:  presc_top = PRESC_W'(P_DIV_100 - 1);
      CS_10:   presc_top = PRESC_W'(P_DIV_10 - 1);
      default: presc_top = PRESC_W'(P_DIV_1 - 1);
    endcase
  endfunction

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // register port decode
  assign wr_en   = i_ce & i_bus_req.cs & i_bus_req.wr;
  assign rd_en   = i_ce & i_bus_req.cs & i_bus_req.rd;
  assign gate    = {i_gate_input_timer_one, i_gate_input_timer_zero};
  assign t1_fall = t1_prev_q & ~out_q[1];

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      ctrl_wr[t] = wr_en & ~page_q & ~blk_q & (i_bus_req.addr == (t == 0 ? ADDR_T0_CTRL : ADDR_T1_CTRL));
      lo_wr[t]   = wr_en & ~page_q & (i_bus_req.addr == data_addr(t, 1'b0));
      hi_wr[t]   = wr_en & ~page_q & (i_bus_req.addr == data_addr(t, 1'b1));
      lo_rd[t]   = rd_en & ~page_q & (i_bus_req.addr == data_addr(t, 1'b0));
      preset[t]  = {pre_hi_q[t], pre_lo_q[t]};
      unique case (ctrl_q[t].clk_sel)
        CS_CASCADE:   tick[t] = (t == 0) ? t1_fall : 1'b0;
        CS_XTAL:      tick[t] = i_xtal_tick;
        CS_XTAL_DIV4: tick[t] = i_xtal_tick & (presc_q[t][1:0] == 2'h3);
        default:      tick[t] = (presc_q[t] == presc_top(ctrl_q[t].clk_sel));
      endcase
      held[t]    = (ctrl_q[t].mode != MODE_ONESHOT) & (ctrl_q[t].count_hold_gate_bit | gate[t]);
      tick_en[t] = i_ce & ctrl_q[t].timer_run_bit & ~held[t] & tick[t];
      trig[t]    = i_ce & ctrl_q[t].timer_run_bit & (ctrl_q[t].mode == MODE_ONESHOT)
                   & ((ctrl_wr[t] & i_bus_req.wdata[7]) | (gate[t] & ~gate_prev_q[t]));
      done[t]    = tick_en[t] & (ctrl_q[t].mode == MODE_SINGLE) & loaded_q[t] & (cnt_q[t] <= 16'h0001);
    end
  end

  // control, preset and page registers
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < 2; t++) begin
        ctrl_q[t]   <= dmt_ctrl_t'(CTRL_RST);
        pre_lo_q[t] <= PRESET_RST;
        pre_hi_q[t] <= PRESET_RST;
        snap_q[t]   <= 16'h0000;
      end
      page_q <= 1'b0;
      blk_q  <= 1'b0;
      om_q   <= OM_RST;
    end else if (i_ce) begin
      if (wr_en && i_bus_req.addr == ADDR_STATUS) begin
        page_q <= i_bus_req.wdata[ST_PS_BIT];
        blk_q  <= i_bus_req.wdata[ST_RS_BIT];
      end
      if (wr_en && !page_q && blk_q && i_bus_req.addr == ADDR_OUT_MODE) begin
        om_q <= i_bus_req.wdata[1:0];
      end
      for (int t = 0; t < 2; t++) begin
        if (lo_wr[t]) begin
          pre_lo_q[t] <= i_bus_req.wdata;
        end
        if (hi_wr[t]) begin
          pre_hi_q[t] <= i_bus_req.wdata;
        end
        if (ctrl_wr[t]) begin
          ctrl_q[t] <= dmt_ctrl_t'(i_bus_req.wdata);
          if (i_bus_req.wdata[6]) begin
            snap_q[t] <= cnt_q[t];
          end
        end else begin
          if (done[t]) begin
            ctrl_q[t].timer_run_bit <= 1'b0;
          end
          if (lo_rd[t]) begin
            ctrl_q[t].read_latch <= 1'b0;
          end
        end
      end
    end
  end

  // prescalers
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q[0] <= '0;
      presc_q[1] <= '0;
    end else if (i_ce) begin
      for (int t = 0; t < 2; t++) begin
        if (!ctrl_q[t].timer_run_bit) begin
          presc_q[t] <= '0;
        end else if (!held[t]) begin
          if (ctrl_q[t].clk_sel == CS_XTAL_DIV4) begin
            if (i_xtal_tick) begin
              presc_q[t] <= {{(PRESC_W-2){1'b0}}, presc_q[t][1:0] + 2'h1};
            end
          end else if (ctrl_q[t].clk_sel >= CS_10K7) begin
            presc_q[t] <= tick[t] ? '0 : presc_q[t] + 1'b1;
          end
        end
      end
    end
  end

  // counters and outputs
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < 2; t++) begin
        cnt_q[t] <= 16'h0000;
      end
      out_q       <= 2'h0;
      loaded_q    <= 2'h0;
      pend_q      <= 2'h0;
      gate_prev_q <= 2'h0;
      irq_q       <= 2'h0;
      t1_prev_q   <= 1'b0;
    end else if (i_ce) begin
      gate_prev_q <= gate;
      t1_prev_q   <= out_q[1];
      irq_q       <= 2'h0;
      for (int t = 0; t < 2; t++) begin
        if (!ctrl_q[t].timer_run_bit) begin
          cnt_q[t]    <= 16'h0000;
          out_q[t]    <= 1'b0;
          loaded_q[t] <= 1'b0;
          pend_q[t]   <= 1'b0;
        end else if (trig[t]) begin
          out_q[t]    <= 1'b1;
          pend_q[t]   <= 1'b1;
          loaded_q[t] <= 1'b0;
        end else if (tick_en[t]) begin
          unique case (ctrl_q[t].mode)
            MODE_ONESHOT: begin
              if (pend_q[t]) begin
                cnt_q[t]    <= preset[t];
                pend_q[t]   <= 1'b0;
                loaded_q[t] <= 1'b1;
              end else if (loaded_q[t]) begin
                cnt_q[t] <= cnt_q[t] - 16'h0001;
                if (cnt_q[t] <= 16'h0001) begin
                  cnt_q[t]    <= 16'h0000;
                  out_q[t]    <= 1'b0;
                  loaded_q[t] <= 1'b0;
                  irq_q[t]    <= 1'b1;
                end
              end
            end
            default: begin
              if (!loaded_q[t]) begin
                cnt_q[t]    <= preset[t];
                out_q[t]    <= 1'b1;
                loaded_q[t] <= 1'b1;
              end else if (ctrl_q[t].mode == MODE_SINGLE) begin
                cnt_q[t] <= cnt_q[t] - 16'h0001;
                if (cnt_q[t] <= 16'h0001) begin
                  cnt_q[t] <= 16'h0000;
                  out_q[t] <= 1'b0;
                  irq_q[t] <= 1'b1;
                end
              end else if (cnt_q[t] == 16'h0000) begin
                cnt_q[t] <= preset[t];
                if (ctrl_q[t].mode == MODE_RATE) begin
                  out_q[t] <= 1'b1;
                end else begin
                  out_q[t] <= ~out_q[t];
                  irq_q[t] <= out_q[t];
                end
              end else begin
                cnt_q[t] <= cnt_q[t] - 16'h0001;
                if (ctrl_q[t].mode == MODE_RATE && cnt_q[t] == 16'h0001) begin
                  out_q[t] <= 1'b0;
                  irq_q[t] <= 1'b1;
                end
              end
            end
          endcase
        end
      end
    end
  end

  // read data and output pin
  always_comb begin
    rdata_d = 8'h00;
    if (i_bus_req.addr == ADDR_STATUS) begin
      rdata_d[ST_PS_BIT] = page_q;
      rdata_d[ST_RS_BIT] = blk_q;
    end else if (!page_q) begin
      if (!blk_q && i_bus_req.addr == ADDR_T0_CTRL) begin
        rdata_d = ctrl_q[0];
      end else if (!blk_q && i_bus_req.addr == ADDR_T1_CTRL) begin
        rdata_d = ctrl_q[1];
      end else if (blk_q && i_bus_req.addr == ADDR_OUT_MODE) begin
        rdata_d = {6'h00, om_q};
      end
      for (int t = 0; t < 2; t++) begin
        if (i_bus_req.addr == data_addr(t, 1'b0)) begin
          rdata_d = ctrl_q[t].read_latch ? snap_q[t][7:0] : pre_lo_q[t];
        end else if (i_bus_req.addr == data_addr(t, 1'b1)) begin
          rdata_d = ctrl_q[t].read_latch ? snap_q[t][15:8] : pre_hi_q[t];
        end
      end
    end
  end

  assign mfo_val = out_q[0] ^ om_q[OM_INV_BIT];

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q  <= 8'h00;
      mfo_o_q  <= 1'b0;
      mfo_oe_q <= 1'b1;
    end else if (i_ce) begin
      if (rd_en) begin
        rdata_q <= rdata_d;
      end
      mfo_o_q  <= om_q[OM_OD_BIT] ? 1'b0 : mfo_val;
      mfo_oe_q <= om_q[OM_OD_BIT] ? ~mfo_val : 1'b1;
    end
  end

  assign o_rdata                    = rdata_q;
  assign o_multi_function_output_o  = mfo_o_q;
  assign o_multi_function_output_oe = mfo_oe_q;
  assign o_timer_irq                = irq_q;

  a_stop_clears_timer: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_ce && !ctrl_q[0].timer_run_bit) |=> (!out_q[0] && cnt_q[0] == 16'h0000 && presc_q[0] == '0))
    else $error("stopped timer not cleared");

  a_single_done_run: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_ce && done[0] && !ctrl_wr[0]) |=> (!ctrl_q[0].timer_run_bit && irq_q[0] && !out_q[0]))
    else $error("single pulse end did not clear run and interrupt");

  a_single_fall_zero: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    ($fell(out_q[0]) && ctrl_q[0].mode == MODE_SINGLE) |-> cnt_q[0] == 16'h0000)
    else $error("single pulse fell before zero");

  a_rate_reload_high: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (tick_en[0] && !trig[0] && ctrl_q[0].mode == MODE_RATE && loaded_q[0] && cnt_q[0] == 16'h0000)
    |=> (cnt_q[0] == $past(preset[0]) && out_q[0]))
    else $error("rate mode did not reload after zero");

  a_square_irq_fall: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (irq_q[0] && ctrl_q[0].mode == MODE_SQUARE) |-> $fell(out_q[0]))
    else $error("square interrupt without falling output");

  a_hold_freezes_count: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (ctrl_q[0].timer_run_bit && held[0]) |=> $stable(cnt_q[0]))
    else $error("held timer changed count");

  a_trigger_sets_out: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    trig[0] |=> (out_q[0] && pend_q[0]))
    else $error("trigger did not set output");

  a_low_read_unlatch: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (lo_rd[0] && !ctrl_wr[0]) |=> !ctrl_q[0].read_latch)
    else $error("low byte read left latch set");

  a_preset_readback: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (lo_rd[0] && !ctrl_q[0].read_latch && !wr_en) |=> o_rdata == $past(pre_lo_q[0]))
    else $error("data read did not return preset");

  a_open_drain_low: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (i_ce && om_q[OM_OD_BIT]) |=> !o_multi_function_output_o)
    else $error("open drain pin driven high");

endmodule

//--- sim/dmt_host_model.sv
`timescale 1ns/1ps
module dmt_host_model
  import dmt_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_xtal_tick,
  output dmt_bus_req_t    o_bus_req,
  input  wire logic [7:0] i_rdata
);
  initial o_bus_req = '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: 5'h1F, wdata: 8'hA5};

  // one-cycle strobe; answer taken 1 ns after the accepting edge
  task automatic cycle(input logic is_wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge i_core_clk);
    #1;
    o_bus_req = '{cs: 1'b1, rd: !is_wr, wr: is_wr, addr: a, wdata: d};
    @(posedge i_core_clk);
    #1;
    q = i_rdata;
    // idle lines carry the inverse so stale values are never relied on
    o_bus_req = '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    cycle(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    cycle(1'b0, a, 8'h00, q);
  endtask

  // latch request aligned to the decrement tick
  task automatic wr_sync(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_core_clk iff i_xtal_tick);
    wr(a, d);
  endtask
endmodule

//--- sim/dual_multimode_down_timer_tb.sv
`timescale 1ns/1ps
module dual_multimode_down_timer_tb;
  import dmt_pkg::*;
  logic         i_core_clk, i_rst_b, i_xtal_tick, gate0, gate1, ce, multi_function_output, mfo_oe;
  logic [1:0]   tick_q, irq, seen;
  logic [7:0]   rdata, q, r;
  dmt_bus_req_t req;
  int           err_count, total_checks, cyc, seed, n, w, g;
  localparam int TP[8] = '{0, 4, 16, 8, 16, 32, 64, 128};

  dmt_timer #(.P_DIV_10K7(8), .P_DIV_1K(16), .P_DIV_100(32), .P_DIV_10(64), .P_DIV_1(128)) dmt_timer_inst (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_bus_req(req), .o_rdata(rdata),
    .i_xtal_tick(i_xtal_tick), .i_gate_input_timer_zero(gate0), .i_gate_input_timer_one(gate1),
    .o_multi_function_output_o(multi_function_output), .o_multi_function_output_oe(mfo_oe), .o_timer_irq(irq));
  dmt_host_model dmt_host_model_inst (.i_core_clk(i_core_clk), .i_xtal_tick(i_xtal_tick),
    .o_bus_req(req), .i_rdata(rdata));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial begin
    tick_q = 2'h0;
    i_xtal_tick = 1'b0;
  end
  // crystal tick every fourth core cycle
  always @(posedge i_core_clk) begin
    tick_q <= tick_q + 2'h1;
    i_xtal_tick <= (tick_q == 2'h3);
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  function automatic logic [7:0] ctl(input dmt_mode_t m, input logic [2:0] cs, input logic run, input logic hold,
                                     input logic lat);
    dmt_ctrl_t c;
    c = '{count_hold_gate_bit: hold, read_latch: lat, clk_sel: cs, mode: m, timer_run_bit: run};
    return c;
  endfunction

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    dmt_host_model_inst.wr(a, d);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    dmt_host_model_inst.rd(a, d);
  endtask

  // preset, then control with run low, then run high
  task automatic start(input logic t, input dmt_mode_t m, input logic [2:0] cs, input logic [15:0] v);
    wr(t ? ADDR_T1_LOW : ADDR_T0_LOW, v[7:0]);
    wr(t ? ADDR_T1_HIGH : ADDR_T0_HIGH, v[15:8]);
    wr(t ? ADDR_T1_CTRL : ADDR_T0_CTRL, ctl(m, cs, 1'b0, 1'b0, 1'b0));
    wr(t ? ADDR_T1_CTRL : ADDR_T0_CTRL, ctl(m, cs, 1'b1, 1'b0, 1'b0));
  endtask

  task automatic hi_width(output int wd);
    int k;
    k = 0;
    wd = 0;
    seen = 2'h0;
    while (multi_function_output !== 1'b1 && k < 3000) begin
      @(posedge i_core_clk);
      #2 k++;
    end
    while (multi_function_output === 1'b1 && wd < 3000) begin
      @(posedge i_core_clk);
      #2 wd++;
      seen |= irq;
    end
    repeat (3) begin
      @(posedge i_core_clk);
      #2 seen |= irq;
    end
  endtask

  task automatic irq_gap(output int gp);
    int k;
    k = 0;
    gp = 0;
    while (irq[0] !== 1'b1 && k < 3000) begin
      @(posedge i_core_clk);
      #2 k++;
    end
    do begin
      @(posedge i_core_clk);
      #2 gp++;
    end while (irq[0] !== 1'b1 && gp < 3000);
  endtask

  initial begin
    seed = 40;
    gate0 = 1'b0;
    gate1 = 1'b0;
    ce = 1'b1;
    i_rst_b = 1'b0;
    err_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (4) @(posedge i_core_clk);
    #1 i_rst_b = 1'b1;
    repeat (4) @(posedge i_core_clk);
    #2 chk({rdata, multi_function_output, mfo_oe, irq}, {8'h00, 1'b0, 1'b1, 2'h0}, "reset outputs");
    for (int i = 0; i < 4; i++) begin
      q = 8'($random(seed));
      wr(ADDR_T0_LOW + 5'(i), q);
      rd(ADDR_T0_LOW + 5'(i), r);
      chk(r, q, "preset readback");
    end
    rd(5'h13, r);
    chk(r, 8'h00, "unmapped read");
    wr(ADDR_STATUS, 8'h80);
    rd(ADDR_T0_LOW, r);
    chk(r, 8'h00, "second page read");
    wr(ADDR_STATUS, 8'h00);
    $display("test registers done");
    for (int s = 1; s < 8; s++) begin
      start(1'b0, MODE_RATE, 3'(s), 16'h0001);
      irq_gap(g);
      chk(16'(g), 16'(2 * TP[s]), "period per clock select");
    end
    $display("test clock select done");
    n = 2 + {$random(seed)} % 4;
    start(1'b0, MODE_SINGLE, CS_XTAL, 16'(n));
    hi_width(w);
    chk(16'(w), 16'(4 * n), "single pulse width");
    chk(16'(seen[0]), 16'h1, "single pulse irq");
    wr(ADDR_T0_CTRL, ctl(MODE_SINGLE, CS_XTAL, 1'b1, 1'b0, 1'b0));
    fork
      hi_width(w);
      begin
        @(posedge multi_function_output);
        repeat (5) @(posedge i_core_clk);
        #1 gate0 = 1'b1;
        repeat (8) @(posedge i_core_clk);
        #1 gate0 = 1'b0;
      end
    join
    chk(16'(w), 16'(4 * n + 8), "restart after auto stop, gate pause");
    wr(ADDR_T0_CTRL, ctl(MODE_SINGLE, CS_XTAL, 1'b1, 1'b0, 1'b0));
    fork
      hi_width(w);
      begin
        @(posedge multi_function_output);
        repeat (5) @(posedge i_core_clk);
        #1 ce = 1'b0;
        repeat (8) @(posedge i_core_clk);
        #1 ce = 1'b1;
      end
    join
    chk(16'(w), 16'(4 * n + 8), "clock enable freeze");
    $display("test single pulse done");
    start(1'b0, MODE_RATE, CS_XTAL, 16'(n));
    irq_gap(g);
    chk(16'(g), 16'(4 * (n + 1)), "rate period");
    hi_width(w);
    hi_width(w);
    chk(16'(w), 16'(4 * n), "rate high time");
    start(1'b0, MODE_SQUARE, CS_XTAL, 16'(n));
    irq_gap(g);
    chk(16'(g), 16'(8 * (n + 1)), "square irq period");
    hi_width(w);
    hi_width(w);
    chk(16'(w), 16'(4 * (n + 1)), "square half period");
    $display("test rate and square done");
    start(1'b0, MODE_ONESHOT, CS_XTAL, 16'(n));
    w = 0;
    repeat (40) begin
      @(posedge i_core_clk);
      #2 w += int'(multi_function_output === 1'b1);
    end
    chk(16'(w), 16'h0, "one-shot idle before trigger");
    @(posedge i_core_clk);
    #1 gate0 = 1'b1;
    fork
      hi_width(w);
      begin
        repeat (3) @(posedge i_core_clk);
        #1 gate0 = 1'b0;
      end
    join
    chk(16'(w >= 4 * n && w <= 4 * n + 4 && seen[0]), 16'h1, "one-shot width and irq");
    fork
      hi_width(w);
      begin
        wr(ADDR_T0_CTRL, ctl(MODE_ONESHOT, CS_XTAL, 1'b1, 1'b1, 1'b0));
        repeat (2 * n) @(posedge i_core_clk);
        wr(ADDR_T0_CTRL, ctl(MODE_ONESHOT, CS_XTAL, 1'b1, 1'b1, 1'b0));
      end
    join
    chk(16'(w >= 6 * n && w <= 6 * n + 6), 16'h1, "retriggered width");
    $display("test one-shot done");
    wr(ADDR_T0_CTRL, 8'h00);
    start(1'b1, MODE_RATE, CS_XTAL, 16'h01C3);
    w = 0;
    repeat (100) begin
      @(posedge i_core_clk);
      #2 w += int'(multi_function_output === 1'b1);
    end
    chk(16'(w), 16'h0, "timer one kept off pin");
    dmt_host_model_inst.wr_sync(ADDR_T1_CTRL, ctl(MODE_RATE, CS_XTAL, 1'b1, 1'b0, 1'b1));
    rd(ADDR_T1_HIGH, r);
    rd(ADDR_T1_LOW, q);
    chk(16'({r, q} < 16'h01C3 && {r, q} > 16'h0100), 16'h1, "latched count");
    rd(ADDR_T1_LOW, q);
    chk(q, 8'hC3, "preset after low read");
    wr(ADDR_T1_CTRL, ctl(MODE_RATE, CS_XTAL, 1'b1, 1'b0, 1'b1));
    wr(ADDR_T1_CTRL, ctl(MODE_RATE, CS_XTAL, 1'b1, 1'b0, 1'b0));
    rd(ADDR_T1_LOW, q);
    chk(q, 8'hC3, "latch abandoned");
    start(1'b1, MODE_RATE, CS_XTAL, 16'h0003);
    start(1'b0, MODE_SINGLE, CS_CASCADE, 16'h0002);
    hi_width(w);
    chk(16'(w), 16'(2 * 4 * 4), "cascaded pulse width");
    @(posedge i_core_clk);
    #1 gate1 = 1'b1;
    start(1'b1, MODE_SINGLE, CS_XTAL, 16'(n));
    g = 0;
    repeat (40) begin
      @(posedge i_core_clk);
      #2 g += int'(irq[1] === 1'b1);
    end
    @(posedge i_core_clk);
    #1 gate1 = 1'b0;
    w = 0;
    repeat (4 * n + 12) begin
      @(posedge i_core_clk);
      #2 w += int'(irq[1] === 1'b1);
    end
    chk(16'(g), 16'h0, "gate one holds timer one");
    chk(16'(w), 16'h1, "timer one single pulse irq");
    $display("test latch and cascade done");
    wr(ADDR_T0_CTRL, 8'h00);
    wr(ADDR_STATUS, 8'h40);
    wr(ADDR_OUT_MODE, 8'h01);
    repeat (2) @(posedge i_core_clk);
    #2 chk({multi_function_output, mfo_oe}, 2'b11, "inverted idle level");
    wr(ADDR_OUT_MODE, 8'h03);
    repeat (2) @(posedge i_core_clk);
    #2 chk(mfo_oe, 1'b0, "open drain releases high level");
    $display("test output mode done");
    end_of_test();
  end
endmodule
